// [logic/sld_pkg.sv]
// constants and register map for the load measurement and stall detection block
package sld_pkg;

  // ----------------------------------------
  // widths and measurement constants
  // ----------------------------------------
  localparam int LOAD_W    = 10;
  localparam int SENS_W    = 7;
  localparam int VEL_W     = 20;
  localparam int CALC_W    = 16;
  localparam int OFF_SHIFT = 4;
  localparam int FILT_CW   = 2;

  localparam logic [LOAD_W-1:0]        LOAD_MAX      = 10'h3FF;
  localparam logic [LOAD_W-1:0]        LOAD_RST      = 10'h3FF;
  localparam logic signed [CALC_W-1:0] CALC_LOAD_MAX = 16'sh03FF;
  localparam logic [FILT_CW-1:0]       FILT_LAST     = 2'h3;
  localparam logic signed [SENS_W-1:0] SENS_MAX      = 7'sh3F;
  localparam logic signed [SENS_W-1:0] SENS_RST      = 7'sh00;
  localparam logic [VEL_W-1:0]         VLOW_RST      = 20'h00000;
  localparam logic [VEL_W-1:0]         VHIGH_RST     = 20'hFFFFF;

  // ----------------------------------------
  // controller register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] SENS_OFS     = 8'h04;
  localparam logic [ADDR_W-1:0] VLOW_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] VHIGH_OFS    = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] INT_EN_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] INT_CLR_OFS  = 8'h1C;

  localparam int CTRL_W         = 4;
  localparam int CTRL_FILT_BIT  = 0;
  localparam int CTRL_DIAGA_BIT = 1;
  localparam int CTRL_DIAGB_BIT = 2;
  localparam int CTRL_STOP_BIT  = 3;
  localparam int CTRL_TUNE_BIT  = 4;
  localparam int CTRL_RUN_BIT   = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  localparam int STAT_STOP_BIT = 16;
  localparam int STAT_TUNE_BIT = 17;

  localparam int INT_W         = 3;
  localparam int INT_STALL_BIT = 0;
  localparam int INT_TUNE_BIT  = 1;
  localparam int INT_UPD_BIT   = 2;
  localparam logic [INT_W-1:0] INT_RST = 3'h0;

  typedef enum logic [1:0] {
    TUNE_IDLE   = 2'b00,
    TUNE_SETTLE = 2'b01,
    TUNE_CHECK  = 2'b10
  } sld_tune_e;

endpackage

// [logic/sld_link_if.sv]
// link between the stall detection device and its motion controller
`timescale 1ns/1ps
`default_nettype none
interface sld_link_if;
  logic                                    filter_en;
  logic                                    diag_sel_a;
  logic                                    diag_sel_b;
  logic signed [sld_pkg::SENS_W-1:0]       load_sensitivity_offset;
  logic        [sld_pkg::VEL_W-1:0]        lower_velocity_limit;
  logic        [sld_pkg::VEL_W-1:0]        upper_velocity_limit;
  logic        [sld_pkg::LOAD_W-1:0]       load_measure_value;
  logic                                    load_update;
  logic                                    diag_out_a;
  logic                                    diag_out_b;

  modport dev (
    input  filter_en,
    input  diag_sel_a,
    input  diag_sel_b,
    input  load_sensitivity_offset,
    input  lower_velocity_limit,
    input  upper_velocity_limit,
    output load_measure_value,
    output load_update,
    output diag_out_a,
    output diag_out_b
  );

  modport ctl (
    output filter_en,
    output diag_sel_a,
    output diag_sel_b,
    output load_sensitivity_offset,
    output lower_velocity_limit,
    output upper_velocity_limit,
    input  load_measure_value,
    input  load_update,
    input  diag_out_a,
    input  diag_out_b
  );
endinterface
`default_nettype wire

// [logic/sld_device.sv]
// device end: load value post-processing, velocity window and stall report
`timescale 1ns/1ps
`default_nettype none
module sld_device (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [sld_pkg::LOAD_W-1:0]    raw_measure,
  input  wire logic                          raw_valid,
  input  wire logic [sld_pkg::VEL_W-1:0]     velocity,
  output logic                               stall_flag,
  output logic                               detect_active,
  sld_link_if.dev                            link
);

  // ----------------------------------------
  // offset correction
  // ----------------------------------------
  // adds the signed offset, scaled, and clamps into the unsigned value range
  function automatic logic [sld_pkg::LOAD_W-1:0] sld_apply(
    input logic        [sld_pkg::LOAD_W-1:0] raw,
    input logic signed [sld_pkg::SENS_W-1:0] off
  );
    logic signed [sld_pkg::CALC_W-1:0] raw_x;
    logic signed [sld_pkg::CALC_W-1:0] off_x;
    logic signed [sld_pkg::CALC_W-1:0] sum;
    raw_x = $signed({{(sld_pkg::CALC_W-sld_pkg::LOAD_W){1'b0}}, raw});
    off_x = $signed({{(sld_pkg::CALC_W-sld_pkg::SENS_W){off[sld_pkg::SENS_W-1]}}, off});
    sum   = raw_x + (off_x <<< sld_pkg::OFF_SHIFT);
    if (sum[sld_pkg::CALC_W-1]) begin
      sld_apply = '0;
    end else if (sum > sld_pkg::CALC_LOAD_MAX) begin
      sld_apply = sld_pkg::LOAD_MAX;
    end else begin
      sld_apply = sum[sld_pkg::LOAD_W-1:0];
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [sld_pkg::LOAD_W-1:0]  value_r;
  logic [sld_pkg::LOAD_W-1:0]  value_nxt;
  logic [sld_pkg::LOAD_W+1:0]  acc_r;
  logic [sld_pkg::LOAD_W+1:0]  acc_nxt;
  logic [sld_pkg::FILT_CW-1:0] cnt_r;
  logic [sld_pkg::FILT_CW-1:0] cnt_nxt;
  logic                        upd_r;
  logic                        stall_r;
  logic                        stall_nxt;
  logic                        diag_a_r;
  logic                        diag_b_r;

  // ----------------------------------------
  // measurement path
  // ----------------------------------------
  wire logic [sld_pkg::LOAD_W-1:0] adj_value;
  wire logic                       filt;
  wire logic                       grp_last;
  wire logic                       publish;
  wire logic [sld_pkg::LOAD_W+1:0] acc_sum;
  wire logic [sld_pkg::LOAD_W-1:0] new_value;

  // offset taken as two's complement, negative makes readings lower
  assign adj_value = sld_apply(raw_measure, link.load_sensitivity_offset);
  assign filt      = link.filter_en;
  assign grp_last  = (cnt_r == sld_pkg::FILT_LAST);

  // one new value per full step, or per group of four when filtering
  assign publish   = raw_valid & (~filt | grp_last);

  assign acc_sum   = acc_r + {2'b00, adj_value};

  // average of the four samples of the group
  assign new_value = filt ? acc_sum[sld_pkg::LOAD_W+1:2] : adj_value;

  // partial sum restarts when filtering is off or a group completes
  assign acc_nxt   = (~filt) ? '0 :
                     (raw_valid & grp_last) ? '0 :
                     raw_valid ? acc_sum : acc_r;

  // group phase is dropped when the filter is switched off
  assign cnt_nxt   = (~filt) ? '0 :
                     raw_valid ? cnt_r + 2'h1 : cnt_r;

  assign value_nxt = publish ? new_value : value_r;

  // ----------------------------------------
  // velocity window
  // ----------------------------------------
  wire logic low_set;
  wire logic above_low;
  wire logic below_high;

  // a zero lower limit leaves detection switched off
  assign low_set    = (link.lower_velocity_limit != '0);
  assign above_low  = (velocity >= link.lower_velocity_limit);
  assign below_high = (velocity <= link.upper_velocity_limit);

  assign detect_active = low_set & above_low & below_high;

  // ----------------------------------------
  // stall decision
  // ----------------------------------------
  // stall raised with the zero value, dropped at the next full step
  assign stall_nxt = publish ? ((new_value == '0) & detect_active) :
                     raw_valid ? 1'b0 : stall_r;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= sld_pkg::LOAD_RST;
      acc_r   <= '0;
      cnt_r   <= '0;
      upd_r   <= 1'b0;
    end else begin
      value_r <= value_nxt;
      acc_r   <= acc_nxt;
      cnt_r   <= cnt_nxt;
      upd_r   <= publish;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_r  <= 1'b0;
      diag_a_r <= 1'b0;
      diag_b_r <= 1'b0;
    end else begin
      stall_r  <= stall_nxt;
      diag_a_r <= stall_nxt & link.diag_sel_a;
      diag_b_r <= stall_nxt & link.diag_sel_b;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.load_measure_value = value_r;
  assign link.load_update        = upd_r;
  assign link.diag_out_a         = diag_a_r;
  assign link.diag_out_b         = diag_b_r;
  assign stall_flag              = stall_r;

endmodule
`default_nettype wire

// [logic/sld_controller.sv]
// controller end: apb registers, stall reaction, offset auto tuning, interrupt
`timescale 1ns/1ps
`default_nettype none
module sld_controller (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [sld_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               irq,
  output logic                               motor_stop,
  sld_link_if.ctl                            link
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [sld_pkg::CTRL_W-1:0]        ctrl_r;
  logic signed [sld_pkg::SENS_W-1:0] sens_r;
  logic signed [sld_pkg::SENS_W-1:0] sens_nxt;
  logic [sld_pkg::VEL_W-1:0]         vlow_r;
  logic [sld_pkg::VEL_W-1:0]         vhigh_r;
  logic [sld_pkg::INT_W-1:0]         int_stat_r;
  logic [sld_pkg::INT_W-1:0]         int_en_r;
  logic                              stop_r;
  logic [31:0]                       prdata_r;
  logic [2:0]                        syn_a_r;
  logic [2:0]                        syn_b_r;
  sld_pkg::sld_tune_e                tune_r;
  sld_pkg::sld_tune_e                tune_nxt;
  logic                              tune_done;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic acc_ph;
  wire logic wr;
  wire logic rd_setup;
  wire logic hit_ctrl;
  wire logic hit_sens;
  wire logic hit_vlow;
  wire logic hit_vhigh;
  wire logic hit_status;
  wire logic hit_istat;
  wire logic hit_ien;
  wire logic hit_iclr;
  wire logic hit_any;
  wire logic [31:0] rd_mux;

  assign acc_ph     = psel & penable;
  assign wr         = acc_ph & pwrite;
  assign rd_setup   = psel & ~penable & ~pwrite;
  assign hit_ctrl   = (paddr == sld_pkg::CTRL_OFS);
  assign hit_sens   = (paddr == sld_pkg::SENS_OFS);
  assign hit_vlow   = (paddr == sld_pkg::VLOW_OFS);
  assign hit_vhigh  = (paddr == sld_pkg::VHIGH_OFS);
  assign hit_status = (paddr == sld_pkg::STATUS_OFS);
  assign hit_istat  = (paddr == sld_pkg::INT_STAT_OFS);
  assign hit_ien    = (paddr == sld_pkg::INT_EN_OFS);
  assign hit_iclr   = (paddr == sld_pkg::INT_CLR_OFS);
  assign hit_any    = hit_ctrl | hit_sens | hit_vlow | hit_vhigh |
                      hit_status | hit_istat | hit_ien | hit_iclr;

  assign rd_mux = hit_ctrl   ? {28'h0000000, ctrl_r} :
                  hit_sens   ? {{(32-sld_pkg::SENS_W){sens_r[sld_pkg::SENS_W-1]}}, sens_r} :
                  hit_vlow   ? {12'h000, vlow_r} :
                  hit_vhigh  ? {12'h000, vhigh_r} :
                  hit_status ? {14'h0000, (tune_r != sld_pkg::TUNE_IDLE), stop_r,
                                6'h00, link.load_measure_value} :
                  hit_istat  ? {29'h00000000, int_stat_r} :
                  hit_ien    ? {29'h00000000, int_en_r} :
                  32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit_any;
  assign prdata  = prdata_r;

  // ----------------------------------------
  // stall pins and events
  // ----------------------------------------
  wire logic stall_evt;
  wire logic tune_go;
  wire logic run_clr;
  wire logic [sld_pkg::INT_W-1:0] ev;
  wire logic [sld_pkg::INT_W-1:0] clr_mask;

  // diag pins pass two flops; third flop only for the rising edge
  assign stall_evt = (syn_a_r[1] & ~syn_a_r[2]) | (syn_b_r[1] & ~syn_b_r[2]);
  assign tune_go   = wr & hit_ctrl & pwdata[sld_pkg::CTRL_TUNE_BIT];
  assign run_clr   = wr & hit_ctrl & pwdata[sld_pkg::CTRL_RUN_BIT];
  assign clr_mask  = (wr & hit_iclr) ? pwdata[sld_pkg::INT_W-1:0] : '0;

  assign ev[sld_pkg::INT_STALL_BIT] = stall_evt;
  assign ev[sld_pkg::INT_TUNE_BIT]  = tune_done;
  assign ev[sld_pkg::INT_UPD_BIT]   = link.load_update;

  assign irq        = |(int_stat_r & int_en_r);
  assign motor_stop = stop_r;

  // ----------------------------------------
  // offset auto tuning
  // ----------------------------------------
  // tuning forces the filter on and ignores one update after each offset change
  always_comb begin
    tune_nxt  = tune_r;
    sens_nxt  = sens_r;
    tune_done = 1'b0;
    case (tune_r)
      sld_pkg::TUNE_IDLE: begin
        if (tune_go) begin
          sens_nxt = sld_pkg::SENS_RST;
          tune_nxt = sld_pkg::TUNE_SETTLE;
        end else if (wr & hit_sens) begin
          sens_nxt = pwdata[sld_pkg::SENS_W-1:0];
        end
      end
      sld_pkg::TUNE_SETTLE: begin
        if (link.load_update) begin
          tune_nxt = sld_pkg::TUNE_CHECK;
        end
      end
      sld_pkg::TUNE_CHECK: begin
        if (link.load_update) begin
          if (link.load_measure_value == '0 && sens_r != sld_pkg::SENS_MAX) begin
            sens_nxt = sens_r + 7'sh01;
            tune_nxt = sld_pkg::TUNE_SETTLE;
          end else begin
            // keep the highest offset that still read zero
            if (link.load_measure_value != '0 && sens_r != sld_pkg::SENS_RST) begin
              sens_nxt = sens_r - 7'sh01;
            end
            tune_nxt  = sld_pkg::TUNE_IDLE;
            tune_done = 1'b1;
          end
        end
      end
      default: begin
        tune_nxt = sld_pkg::TUNE_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= sld_pkg::CTRL_RST;
      vlow_r   <= sld_pkg::VLOW_RST;
      vhigh_r  <= sld_pkg::VHIGH_RST;
      int_en_r <= sld_pkg::INT_RST;
      prdata_r <= 32'h00000000;
    end else begin
      if (wr & hit_ctrl) ctrl_r <= pwdata[sld_pkg::CTRL_W-1:0];
      if (wr & hit_vlow) vlow_r <= pwdata[sld_pkg::VEL_W-1:0];
      if (wr & hit_vhigh) vhigh_r <= pwdata[sld_pkg::VEL_W-1:0];
      if (wr & hit_ien) int_en_r <= pwdata[sld_pkg::INT_W-1:0];
      if (rd_setup) prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_r     <= sld_pkg::SENS_RST;
      tune_r     <= sld_pkg::TUNE_IDLE;
      int_stat_r <= sld_pkg::INT_RST;
      stop_r     <= 1'b0;
      syn_a_r    <= 3'h0;
      syn_b_r    <= 3'h0;
    end else begin
      sens_r     <= sens_nxt;
      tune_r     <= tune_nxt;
      int_stat_r <= (int_stat_r & ~clr_mask) | ev;
      // stop on a single pulse; a new stall wins over the run release
      stop_r     <= (stop_r & ~run_clr) | (stall_evt & ctrl_r[sld_pkg::CTRL_STOP_BIT]);
      syn_a_r    <= {syn_a_r[1:0], link.diag_out_a};
      syn_b_r    <= {syn_b_r[1:0], link.diag_out_b};
    end
  end

  // ----------------------------------------
  // link drive
  // ----------------------------------------
  assign link.filter_en = ctrl_r[sld_pkg::CTRL_FILT_BIT] |
                          (tune_r != sld_pkg::TUNE_IDLE);
  assign link.diag_sel_a              = ctrl_r[sld_pkg::CTRL_DIAGA_BIT];
  assign link.diag_sel_b              = ctrl_r[sld_pkg::CTRL_DIAGB_BIT];
  assign link.load_sensitivity_offset = sens_r;
  assign link.lower_velocity_limit    = vlow_r;
  assign link.upper_velocity_limit    = vhigh_r;

endmodule
`default_nettype wire

// [tb/sld_link_monitor.sv]
// concurrent checks on the link between device and controller
`timescale 1ns/1ps
`default_nettype none
module sld_link_monitor (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       filter_en,
  input wire logic                       diag_sel_a,
  input wire logic                       diag_sel_b,
  input wire logic [sld_pkg::VEL_W-1:0]  lower_velocity_limit,
  input wire logic [sld_pkg::VEL_W-1:0]  upper_velocity_limit,
  input wire logic [sld_pkg::LOAD_W-1:0] load_measure_value,
  input wire logic                       load_update,
  input wire logic                       diag_out_a,
  input wire logic                       diag_out_b
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_value_with_update: assert property ($changed(load_measure_value) |-> load_update)
    else $error("load value changed without update pulse");
  chk_filter_spacing: assert property (load_update && filter_en |=>
    (!load_update || !filter_en)[*3])
    else $error("filtered updates closer than four steps");
  chk_diag_a_zero: assert property (diag_out_a |-> load_measure_value == 10'h000)
    else $error("stall on output a with nonzero value");
  chk_diag_b_zero: assert property (diag_out_b |-> load_measure_value == 10'h000)
    else $error("stall on output b with nonzero value");
  chk_diag_a_update: assert property ($rose(diag_out_a) |-> load_update)
    else $error("stall on output a not tied to an update");
  chk_diag_b_update: assert property ($rose(diag_out_b) |-> load_update && diag_sel_b)
    else $error("stall on output b not tied to an update");
  chk_diag_window: assert property ($rose(diag_out_a || diag_out_b) |->
    lower_velocity_limit != 20'h00000 && lower_velocity_limit <= upper_velocity_limit)
    else $error("stall reported without a velocity window");
  chk_diag_hold: assert property ($fell(diag_out_a) && diag_sel_a && !filter_en |->
    load_update)
    else $error("stall pulse ended before the next step");
endmodule
`default_nettype wire

// [tb/stall_load_detect_test.sv]
// self-checking bench joining the device end and the controller end
`timescale 1ns/1ps
`default_nettype none
module stall_load_detect_test;
  typedef struct packed {
    logic [9:0]  raw;
    logic [6:0]  sens;
    logic [19:0] vel;
    logic [9:0]  val;
    logic        act;
    logic        stall;
  } sld_row_s;
  // window is 100..1000 for every row
  localparam sld_row_s ROWS [10] = '{
    '{10'h0C8, 7'h00, 20'h001F4, 10'h0C8, 1'b1, 1'b0},
    '{10'h000, 7'h00, 20'h001F4, 10'h000, 1'b1, 1'b1},
    '{10'h000, 7'h00, 20'h00063, 10'h000, 1'b0, 1'b0},
    '{10'h000, 7'h00, 20'h003E9, 10'h000, 1'b0, 1'b0},
    '{10'h000, 7'h00, 20'h00064, 10'h000, 1'b1, 1'b1},
    '{10'h000, 7'h00, 20'h003E8, 10'h000, 1'b1, 1'b1},
    '{10'h020, 7'h7E, 20'h001F4, 10'h000, 1'b1, 1'b1},
    '{10'h3E8, 7'h03, 20'h001F4, 10'h3FF, 1'b1, 1'b0},
    '{10'h064, 7'h41, 20'h001F4, 10'h000, 1'b1, 1'b1},
    '{10'h005, 7'h01, 20'h001F4, 10'h015, 1'b1, 1'b0}};

  logic        pclk, presetn, psel, penable, pwrite, raw_valid;
  logic        pready, pslverr, irq, motor_stop, stall_flag, detect_active, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  raw_measure;
  logic [19:0] velocity;
  int          n_mismatch, comparisons, n;
  int          n_upd = 0;

  sld_link_if link_bus ();
  sld_device u_sld_device (.pclk(pclk), .presetn(presetn), .raw_measure(raw_measure),
    .raw_valid(raw_valid), .velocity(velocity), .stall_flag(stall_flag),
    .detect_active(detect_active), .link(link_bus));
  sld_controller u_sld_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .motor_stop(motor_stop), .link(link_bus));
  sld_link_monitor u_mon (.pclk(pclk), .presetn(presetn), .filter_en(link_bus.filter_en),
    .diag_sel_a(link_bus.diag_sel_a), .diag_sel_b(link_bus.diag_sel_b),
    .lower_velocity_limit(link_bus.lower_velocity_limit),
    .upper_velocity_limit(link_bus.upper_velocity_limit),
    .load_measure_value(link_bus.load_measure_value), .load_update(link_bus.load_update),
    .diag_out_a(link_bus.diag_out_a), .diag_out_b(link_bus.diag_out_b));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic send_raw(input logic [9:0] r);
    @(posedge pclk);
    raw_measure <= r;
    raw_valid <= 1'b1;
    @(posedge pclk);
    raw_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------
  // clock, update counter, watchdog, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) if (link_bus.load_update === 1'b1) n_upd <= n_upd + 1;

  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_valid = 1'b0;
    raw_measure = 10'h000;
    velocity = 20'h001F4;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    cmp_word({22'h0, link_bus.load_measure_value}, 32'h000003FF);
    cmp_bit(irq, 1'b0);
    cmp_bit(motor_stop, 1'b0);
    apb(1'b0, sld_pkg::STATUS_OFS, 32'h0);
    cmp_word(rd, 32'h000003FF);
    apb(1'b0, 8'h20, 32'h0);
    cmp_bit(err, 1'b1);
    cmp_word(rd, 32'h0);
    apb(1'b0, sld_pkg::VHIGH_OFS, 32'h0);
    cmp_word(rd, 32'h000FFFFF);
    $display("reset test done");

    apb(1'b1, sld_pkg::VLOW_OFS, 32'h00000064);
    apb(1'b1, sld_pkg::VHIGH_OFS, 32'h000003E8);
    apb(1'b1, sld_pkg::CTRL_OFS, 32'h2);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, sld_pkg::SENS_OFS, {{25{ROWS[i].sens[6]}}, ROWS[i].sens});
      velocity <= ROWS[i].vel;
      send_raw(ROWS[i].raw);
      cmp_word({22'h0, link_bus.load_measure_value}, {22'h0, ROWS[i].val});
      cmp_bit(detect_active, ROWS[i].act);
      cmp_bit(stall_flag, ROWS[i].stall);
      cmp_bit(link_bus.diag_out_a, ROWS[i].stall);
      apb(1'b0, sld_pkg::STATUS_OFS, 32'h0);
      cmp_word(rd & 32'h000003FF, {22'h0, ROWS[i].val});
    end
    $display("table test done");

    apb(1'b1, sld_pkg::SENS_OFS, 32'h0);
    apb(1'b1, sld_pkg::CTRL_OFS, 32'h3);
    n = n_upd;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      raw_valid <= 1'b1;
      raw_measure <= 10'(100 * (k + 1));
    end
    @(posedge pclk);
    raw_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    cmp_word(n_upd - n, 32'h1);
    cmp_word({22'h0, link_bus.load_measure_value}, 32'h000000FA);
    apb(1'b1, sld_pkg::CTRL_OFS, 32'h2);
    $display("filter test done");

    // drop events left over from the earlier tests
    apb(1'b1, sld_pkg::INT_CLR_OFS, 32'h7);
    apb(1'b1, sld_pkg::INT_EN_OFS, 32'h1);
    #1;
    cmp_bit(irq, 1'b0);
    apb(1'b1, sld_pkg::CTRL_OFS, 32'hE);
    send_raw(10'h000);
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    #1;
    cmp_bit(irq, 1'b1);
    cmp_bit(motor_stop, 1'b1);
    cmp_bit(link_bus.diag_out_b, 1'b1);
    apb(1'b0, sld_pkg::INT_STAT_OFS, 32'h0);
    cmp_word(rd & 32'h1, 32'h1);
    apb(1'b1, sld_pkg::INT_EN_OFS, 32'h0);
    #1;
    cmp_bit(irq, 1'b0);
    apb(1'b1, sld_pkg::INT_EN_OFS, 32'h1);
    apb(1'b1, sld_pkg::INT_CLR_OFS, 32'h1);
    #1;
    cmp_bit(irq, 1'b0);
    send_raw(10'h0C8);
    apb(1'b1, sld_pkg::CTRL_OFS, 32'h2E);
    #1;
    cmp_bit(motor_stop, 1'b0);
    $display("stall interrupt test done");

    // auto tune: raw zero reads zero at offset zero but not at offset one, so one step up then back
    apb(1'b1, sld_pkg::INT_CLR_OFS, 32'h7);
    apb(1'b1, sld_pkg::CTRL_OFS, 32'h12);
    n = n_upd;
    for (int k = 0; k < 16; k++) begin
      send_raw(10'h000);
      if (k == 7) begin
        apb(1'b0, sld_pkg::SENS_OFS, 32'h0);
        cmp_word(rd, 32'h00000001);
        apb(1'b0, sld_pkg::STATUS_OFS, 32'h0);
        cmp_word(rd & 32'h00020000, 32'h00020000);
      end
    end
    cmp_word(n_upd - n, 32'h4);
    apb(1'b0, sld_pkg::SENS_OFS, 32'h0);
    cmp_word(rd, 32'h00000000);
    apb(1'b0, sld_pkg::INT_STAT_OFS, 32'h0);
    cmp_word(rd & 32'h2, 32'h2);
    apb(1'b0, sld_pkg::STATUS_OFS, 32'h0);
    cmp_word(rd & 32'h00020000, 32'h0);
    cmp_word({22'h0, link_bus.load_measure_value}, 32'h00000010);
    $display("auto tune test done");
    summarize();
  end
endmodule
`default_nettype wire
